/* File: bench/exec_assertions.sv */
// port checks for the execution datapath
`timescale 1ns/10ps
module exec_assertions
    import exec_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // decoder, memory, stack
    input wire logic        instValid,
    input wire exec_pkg::op_t instOp,
    input wire logic [7:0]  instImm,
    input wire logic [7:0]  memRdData,
    input wire logic [7:0]  memWrData,
    input wire logic        memWrEn,
    input wire logic [9:0]  stackTop,
    input wire logic        stackPop,
    // pipeline and state
    input wire logic        instReady,
    input wire logic        fetchDiscard,
    input wire logic [7:0]  acc,
    input wire logic [9:0]  pc,
    input wire logic        carryFlag,
    input wire logic        nibbleHalfFlag,
    input wire logic        signedWrapFlag,
    input wire logic        zeroFlag
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [3:0] flags;
    logic       take;
    logic [7:0] rdPrev_r;
    assign flags = {signedWrapFlag, zeroFlag, nibbleHalfFlag, carryFlag};
    assign take = instValid && instReady;
    always_ff @(posedge clk) begin
        rdPrev_r <= memRdData;
    end
    property p_mov_am; take && instOp == OP_MOV_AM |=> acc == rdPrev_r && $stable(flags); endproperty
    a_mov_am: assert property (p_mov_am) else $error("acc load from memory wrong");
    property p_mov_ma; take && instOp == OP_MOV_MA |=> memWrEn && memWrData == $past(acc); endproperty
    a_mov_ma: assert property (p_mov_ma) else $error("store of acc wrong");
    property p_nop; take && instOp == OP_NOP |=> pc == $past(pc) + 10'h001 && $stable(acc) && !memWrEn; endproperty
    a_nop: assert property (p_nop) else $error("idle op changed state");
    property p_ret;
        take && instOp inside {OP_RET, OP_RET_AX} |=> stackPop && !instReady && pc == stackTop ##1 !stackPop;
    endproperty
    a_ret: assert property (p_ret) else $error("return sequence wrong");
    property p_ret_acc; take && instOp == OP_RET_AX |=> acc == $past(instImm) && $stable(flags); endproperty
    a_ret_acc: assert property (p_ret_acc) else $error("return value wrong");
    property p_rotl; take && instOp == OP_ROTL |=> memWrEn && memWrData == {rdPrev_r[6:0], rdPrev_r[7]}; endproperty
    a_rotl: assert property (p_rotl) else $error("left rotate wrong");
    property p_rotrc;
        take && instOp == OP_ROTRC |=> memWrData == {$past(carryFlag), rdPrev_r[7:1]} && carryFlag == rdPrev_r[0];
    endproperty
    a_rotrc: assert property (p_rotrc) else $error("right rotate via carry wrong");
    property p_skip_mem;
        take && instOp == OP_DECSKIP |=> memWrEn && memWrData == rdPrev_r - 8'h01
            && fetchDiscard == (memWrData == 8'h00);
    endproperty
    a_skip_mem: assert property (p_skip_mem) else $error("decrement skip wrong");
    property p_skip_acc;
        take && instOp == OP_DECSKIPA |=> !memWrEn && acc == rdPrev_r - 8'h01 && fetchDiscard == (acc == 8'h00);
    endproperty
    a_skip_acc: assert property (p_skip_acc) else $error("decrement to acc wrong");
    property p_dummy; fetchDiscard |-> !instReady ##1 (instReady && $stable(pc)); endproperty
    a_dummy: assert property (p_dummy) else $error("dummy cycle wrong");
    c_ret: cover property (stackPop);
    c_skip: cover property (fetchDiscard);
    c_sub: cover property (take && instOp == OP_SUBBM);
endmodule : exec_assertions
bind mcu_move_logic_rotate_exec exec_assertions u_chk (.clk(clk), .reset(reset), .instValid(instValid),
    .instOp(instOp), .instImm(instImm), .memRdData(memRdData), .memWrData(memWrData), .memWrEn(memWrEn),
    .stackTop(stackTop), .stackPop(stackPop), .instReady(instReady), .fetchDiscard(fetchDiscard), .acc(acc),
    .pc(pc), .carryFlag(carryFlag), .nibbleHalfFlag(nibbleHalfFlag), .signedWrapFlag(signedWrapFlag),
    .zeroFlag(zeroFlag));

/* File: bench/exec_partner.sv */
// data ram and one-level return stack beside the execution datapath
`timescale 1ns/10ps
module exec_partner
    import exec_pkg::*;
(
    // clock
    input  wire logic        clk,
    // data memory
    input  wire logic [4:0]  memAddr,
    input  wire logic [7:0]  memWrData,
    input  wire logic        memWrEn,
    output logic      [7:0]  memRdData,
    // return stack
    input  wire logic        stackPop,
    output logic      [9:0]  stackTop
);
    logic [7:0] mem [32];
    logic [9:0] stackVal;
    // combinational read, write at the edge
    assign memRdData = mem[memAddr];
    // one-level stack keeps its entry after a pop
    assign stackTop = stackPop ? stackVal : stackVal;
    always @(posedge clk) begin
        if (memWrEn) begin
            mem[memAddr] <= memWrData;
        end
    end
endmodule : exec_partner

/* File: bench/tb_top.sv */
// self-checking bench for the execution datapath
`timescale 1ns/10ps
module tb_top;
    import exec_pkg::*;
    logic clk, reset, instValid, memWrEn, stackPop, instReady, fetchDiscard;
    logic carryFlag, nibbleHalfFlag, signedWrapFlag, zeroFlag, cE, hE, wE, zE;
    op_t instOp;
    logic [7:0] instImm, memRdData, memWrData, acc, accE;
    logic [7:0] memE [32];
    logic [4:0] instAddr, memAddr;
    logic [9:0] stackTop, pc, pcE;
    int mismatches, nChecks, cycles;
    logic [7:0] subVals [5] = '{8'h80, 8'h05, 8'hF5, 8'h7F, 8'h00};
    mcu_move_logic_rotate_exec dut (.clk(clk), .reset(reset), .instValid(instValid), .instOp(instOp),
        .instImm(instImm), .instAddr(instAddr), .memRdData(memRdData), .memAddr(memAddr), .memWrData(memWrData),
        .memWrEn(memWrEn), .stackTop(stackTop), .stackPop(stackPop), .instReady(instReady),
        .fetchDiscard(fetchDiscard), .acc(acc), .pc(pc), .carryFlag(carryFlag), .nibbleHalfFlag(nibbleHalfFlag),
        .signedWrapFlag(signedWrapFlag), .zeroFlag(zeroFlag));
    exec_partner u_part (.clk(clk), .memAddr(memAddr), .memWrData(memWrData), .memWrEn(memWrEn),
        .memRdData(memRdData), .stackPop(stackPop), .stackTop(stackTop));
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    task report_and_stop();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task poke(input int a, input logic [7:0] v);
        u_part.mem[a] = v;
        memE[a] = v;
    endtask : poke
    // offer one instruction, model it, compare pulses, state and memory
    task run(input op_t o, input logic [7:0] i, input int a);
        logic [7:0] m;
        logic [8:0] s;
        logic [4:0] h;
        logic wr, skip, ret;
        int n;
        m = memE[a];
        {wr, skip, ret} = 3'h0;
        n = 0;
        instValid <= 1'b1;
        instOp <= o;
        instImm <= i;
        instAddr <= a[4:0];
        #1;
        while (instReady !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        instValid <= 1'b0;
        pcE = pcE + 10'h001;
        s = {1'b0, accE} + {1'b0, ~m} + {8'h00, cE};
        h = {1'b0, accE[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cE};
        case (o)
            OP_MOV_AM: accE = m;
            OP_MOV_AX: accE = i;
            OP_MOV_MA: {wr, memE[a]} = {1'b1, accE};
            OP_OR_AM: begin accE = accE | m; zE = accE == 8'h00; end
            OP_OR_AX: begin accE = accE | i; zE = accE == 8'h00; end
            OP_ORM: begin {wr, memE[a]} = {1'b1, accE | m}; zE = memE[a] == 8'h00; end
            OP_RET, OP_RET_AX: begin pcE = u_part.stackVal; ret = 1'b1; if (o == OP_RET_AX) accE = i; end
            OP_ROTL: {wr, memE[a]} = {1'b1, m[6:0], m[7]};
            OP_ROTLA: accE = {m[6:0], m[7]};
            OP_ROTLC: begin {cE, memE[a]} = {m, cE}; wr = 1'b1; end
            OP_ROTLCA: {cE, accE} = {m, cE};
            OP_ROTR: {wr, memE[a]} = {1'b1, m[0], m[7:1]};
            OP_ROTRA: accE = {m[0], m[7:1]};
            OP_ROTRC: begin {memE[a], cE} = {cE, m}; wr = 1'b1; end
            OP_ROTRCA: {accE, cE} = {cE, m};
            OP_SUBB, OP_SUBBM: begin
                wE = (accE[7] == ~m[7]) && (s[7] != accE[7]);
                {cE, hE, zE} = {s[8], h[4], s[7:0] == 8'h00};
                if (o == OP_SUBB) accE = s[7:0];
                else {wr, memE[a]} = {1'b1, s[7:0]};
            end
            OP_DECSKIP: begin {wr, memE[a]} = {1'b1, m - 8'h01}; skip = m == 8'h01; end
            OP_DECSKIPA: begin accE = m - 8'h01; skip = m == 8'h01; end
            default: ;
        endcase
        if (skip) pcE = pcE + 10'h001;
        #1;
        chk(memWrEn, wr);
        chk(stackPop, ret);
        chk(fetchDiscard, skip);
        chk(instReady, !(ret || skip));
        chk(acc, accE);
        chk(pc, pcE);
        chk({signedWrapFlag, zeroFlag, nibbleHalfFlag, carryFlag}, {wE, zE, hE, cE});
        @(posedge clk);
        #1;
        chk(u_part.mem[a], memE[a]);
    endtask : run
    initial begin
        {reset, instValid, instImm, instAddr} = {2'b10, 13'h0000};
        instOp = OP_NOP;
        {mismatches, nChecks, cycles, accE, pcE, cE, hE, wE, zE} = '0;
        u_part.stackVal = 10'h155;
        for (int k = 0; k < 32; k++) poke(k, 8'h96);
        poke(4, 8'hC3);
        poke(5, 8'h20);
        poke(6, 8'h01);
        poke(9, 8'h05);
        repeat (20) @(posedge clk);
        #1;
        chk({acc, pc, instReady}, {ACC_RST, PC_RST, 1'b0});
        @(posedge clk);
        reset <= 1'b0;
        run(OP_MOV_AX, 8'h5A, 0);
        run(OP_MOV_MA, 8'h00, 3);
        run(OP_MOV_AM, 8'h00, 4);
        run(OP_NOP, 8'hFF, 4);
        run(OP_MOV_AX, 8'h00, 0);
        run(OP_OR_AX, 8'h00, 0);
        run(OP_OR_AX, 8'h10, 0);
        run(OP_OR_AM, 8'h00, 6);
        run(OP_ORM, 8'h00, 5);
        run(OP_RET, 8'h00, 0);
        run(OP_RET_AX, 8'h77, 0);
        for (int k = 0; k < 5; k++) begin
            poke(13, subVals[k]);
            run(OP_SUBB, 8'h00, 13);
        end
        run(OP_SUBBM, 8'h00, 9);
        for (int k = 0; k < 16; k++) begin
            run(op_t'(OP_ROTL + k % 8), 8'h00, 7);
        end
        poke(11, 8'h01);
        run(OP_DECSKIP, 8'h00, 11);
        run(OP_DECSKIP, 8'h00, 11);
        poke(12, 8'h01);
        run(OP_DECSKIPA, 8'h00, 12);
        run(OP_DECSKIPA, 8'h00, 7);
        report_and_stop();
    end
endmodule : tb_top

/* File: common/exec_pkg.sv */
// shared constants and types for the move/logic/rotate execution datapath
package exec_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int PC_W   = 10;

    // ------------------------------------------------------------
    // status flag bit positions
    // ------------------------------------------------------------
    localparam int FLG_CARRY = 0;
    localparam int FLG_HALF  = 1;
    localparam int FLG_ZERO  = 2;
    localparam int FLG_WRAP  = 3;
    localparam int FLG_W     = 4;

    // ------------------------------------------------------------
    // reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [3:0]  FLAGS_RST = 4'h0;
    localparam logic [9:0]  PC_RST    = 10'h000;
    localparam logic [9:0]  PC_STEP   = 10'h001;
    localparam logic [7:0]  ONE_BYTE  = 8'h01;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;
    localparam logic [1:0]  CYC_ONE   = 2'h1;
    localparam logic [1:0]  CYC_TWO   = 2'h2;

    // ------------------------------------------------------------
    // operation select from the decoder
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP      = 5'h00,
        OP_MOV_AM   = 5'h01,
        OP_MOV_AX   = 5'h02,
        OP_MOV_MA   = 5'h03,
        OP_OR_AM    = 5'h04,
        OP_OR_AX    = 5'h05,
        OP_ORM      = 5'h06,
        OP_RET      = 5'h07,
        OP_RET_AX   = 5'h08,
        OP_ROTL     = 5'h09,
        OP_ROTLA    = 5'h0A,
        OP_ROTLC    = 5'h0B,
        OP_ROTLCA   = 5'h0C,
        OP_ROTR     = 5'h0D,
        OP_ROTRA    = 5'h0E,
        OP_ROTRC    = 5'h0F,
        OP_ROTRCA   = 5'h10,
        OP_SUBB     = 5'h11,
        OP_SUBBM    = 5'h12,
        OP_DECSKIP  = 5'h13,
        OP_DECSKIPA = 5'h14
    } op_t;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_EXEC  = 2'b00,
        ST_RET2  = 2'b01,
        ST_DUMMY = 2'b10
    } seq_t;

endpackage : exec_pkg

/* File: hdl/mcu_move_logic_rotate_exec.sv */
// execution datapath for moves, OR, return, rotates, subtract-with-borrow and decrement-skip
// Function
// - move memory to accumulator, flags kept
// - move immediate to accumulator, flags kept
// - store accumulator to memory, flags kept
// - no-op only advances program counter
// - OR memory into accumulator, zero flag
// - OR immediate into accumulator, zero flag
// - OR result back to memory, zero flag
// - return reloads PC, two cycles, flags kept
// - return-with-value also loads immediate into accumulator
// - rotate memory left, bit7 to bit0
// - rotate left into accumulator, memory kept
// - rotate left through carry to memory
// - rotate left through carry into accumulator
// - rotate memory right, bit0 to bit7
// - rotate right into accumulator, memory kept
// - rotate right through carry to memory
// - rotate right through carry into accumulator
// - subtract with borrow into accumulator, four flags
// - subtract with borrow back to memory
// - decrement memory, skip when zero, no flags
// - skip discards prefetch, adds dummy cycle
// - decrement into accumulator, same skip timing
//
`timescale 1ns/10ps
module mcu_move_logic_rotate_exec
    import exec_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // decoded instruction
    input  wire logic                        instValid,
    input  wire exec_pkg::op_t               instOp,
    input  wire logic [exec_pkg::DATA_W-1:0] instImm,
    input  wire logic [exec_pkg::ADDR_W-1:0] instAddr,
    // data memory
    input  wire logic [exec_pkg::DATA_W-1:0] memRdData,
    output logic      [exec_pkg::ADDR_W-1:0] memAddr,
    output logic      [exec_pkg::DATA_W-1:0] memWrData,
    output logic                             memWrEn,
    // return stack
    input  wire logic [exec_pkg::PC_W-1:0]   stackTop,
    output logic                             stackPop,
    // pipeline control
    output logic                             instReady,
    output logic                             fetchDiscard,
    // architectural state
    output logic      [exec_pkg::DATA_W-1:0] acc,
    output logic      [exec_pkg::PC_W-1:0]   pc,
    output logic                             carryFlag,
    output logic                             nibbleHalfFlag,
    output logic                             signedWrapFlag,
    output logic                             zeroFlag
);
    import exec_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] acc_r, acc_nxt;
    logic [PC_W-1:0]   pc_r, pc_nxt;
    logic [FLG_W-1:0]  flags_r, flags_nxt;
    logic [ADDR_W-1:0] memAddr_r, memAddr_nxt;
    logic [DATA_W-1:0] memWr_r, memWr_nxt;
    logic              memWrEn_r, memWrEn_nxt;
    logic              discard_r, discard_nxt;
    logic              pop_r, pop_nxt;
    seq_t              seq_r, seq_nxt;

    // ------------------------------------------------------------
    // functional units
    // ------------------------------------------------------------
    logic              rotRight, rotCarry;
    logic [DATA_W-1:0] rotResult;
    logic              rotCarryOut;
    logic [DATA_W-1:0] subDiff;
    logic              subCarry, subHalf, subWrap, subZero;
    logic [DATA_W-1:0] decResult;
    logic [DATA_W-1:0] orMem, orImm;
    logic              take;

    rotate_unit u_rotate (
        .operand  (memRdData),
        .carryIn  (flags_r[FLG_CARRY]),
        .toRight  (rotRight),
        .viaCarry (rotCarry),
        .result   (rotResult),
        .carryOut (rotCarryOut)
    );

    sub_borrow_unit u_sub (
        .accIn    (acc_r),
        .memIn    (memRdData),
        .carryIn  (flags_r[FLG_CARRY]),
        .diff     (subDiff),
        .carryOut (subCarry),
        .halfOut  (subHalf),
        .wrapOut  (subWrap),
        .zeroOut  (subZero)
    );

    always_comb begin
        rotRight  = (instOp == OP_ROTR) || (instOp == OP_ROTRA)
                 || (instOp == OP_ROTRC) || (instOp == OP_ROTRCA);
        rotCarry  = (instOp == OP_ROTLC) || (instOp == OP_ROTLCA)
                 || (instOp == OP_ROTRC) || (instOp == OP_ROTRCA);
        decResult = memRdData - ONE_BYTE;
        orMem     = acc_r | memRdData;
        orImm     = acc_r | instImm;
        take      = instValid && (seq_r == ST_EXEC);
    end

    // ------------------------------------------------------------
    // next-state decode
    // ------------------------------------------------------------
    always_comb begin
        acc_nxt     = acc_r;
        pc_nxt      = pc_r;
        flags_nxt   = flags_r;
        memAddr_nxt = memAddr_r;
        memWr_nxt   = memWr_r;
        memWrEn_nxt = 1'b0;
        discard_nxt = 1'b0;
        pop_nxt     = 1'b0;
        seq_nxt     = seq_r;
        case (seq_r)
            ST_EXEC: begin
                if (take) begin
                    pc_nxt      = pc_r + PC_STEP;
                    memAddr_nxt = instAddr;
                    case (instOp)
                        OP_NOP: begin
                            pc_nxt = pc_r + PC_STEP;
                        end
                        OP_MOV_AM: begin
                            acc_nxt = memRdData;
                        end
                        OP_MOV_AX: begin
                            acc_nxt = instImm;
                        end
                        OP_MOV_MA: begin
                            memWr_nxt   = acc_r;
                            memWrEn_nxt = 1'b1;
                        end
                        OP_OR_AM: begin
                            acc_nxt             = orMem;
                            flags_nxt[FLG_ZERO] = (orMem == ZERO_BYTE);
                        end
                        OP_OR_AX: begin
                            acc_nxt             = orImm;
                            flags_nxt[FLG_ZERO] = (orImm == ZERO_BYTE);
                        end
                        OP_ORM: begin
                            memWr_nxt           = orMem;
                            memWrEn_nxt         = 1'b1;
                            flags_nxt[FLG_ZERO] = (orMem == ZERO_BYTE);
                        end
                        OP_RET, OP_RET_AX: begin
                            pc_nxt  = stackTop;
                            pop_nxt = 1'b1;
                            seq_nxt = ST_RET2;
                            if (instOp == OP_RET_AX) begin
                                acc_nxt = instImm;
                            end
                        end
                        OP_ROTL, OP_ROTR: begin
                            memWr_nxt   = rotResult;
                            memWrEn_nxt = 1'b1;
                        end
                        OP_ROTLA, OP_ROTRA: begin
                            acc_nxt = rotResult;
                        end
                        OP_ROTLC, OP_ROTRC: begin
                            memWr_nxt            = rotResult;
                            memWrEn_nxt          = 1'b1;
                            flags_nxt[FLG_CARRY] = rotCarryOut;
                        end
                        OP_ROTLCA, OP_ROTRCA: begin
                            acc_nxt              = rotResult;
                            flags_nxt[FLG_CARRY] = rotCarryOut;
                        end
                        OP_SUBB, OP_SUBBM: begin
                            flags_nxt[FLG_CARRY] = subCarry;
                            flags_nxt[FLG_HALF]  = subHalf;
                            flags_nxt[FLG_WRAP]  = subWrap;
                            flags_nxt[FLG_ZERO]  = subZero;
                            if (instOp == OP_SUBBM) begin
                                memWr_nxt   = subDiff;
                                memWrEn_nxt = 1'b1;
                            end else begin
                                acc_nxt = subDiff;
                            end
                        end
                        OP_DECSKIP, OP_DECSKIPA: begin
                            if (instOp == OP_DECSKIP) begin
                                memWr_nxt   = decResult;
                                memWrEn_nxt = 1'b1;
                            end else begin
                                acc_nxt = decResult;
                            end
                            if (decResult == ZERO_BYTE) begin
                                pc_nxt      = pc_r + PC_STEP + PC_STEP;
                                discard_nxt = 1'b1;
                                seq_nxt     = ST_DUMMY;
                            end
                        end
                        default: begin
                            pc_nxt = pc_r + PC_STEP;
                        end
                    endcase
                end
            end
            ST_RET2: begin
                seq_nxt = ST_EXEC;
            end
            ST_DUMMY: begin
                seq_nxt = ST_EXEC;
            end
            default: begin
                seq_nxt = ST_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_r   <= ACC_RST;
            flags_r <= FLAGS_RST;
        end else begin
            acc_r   <= acc_nxt;
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pc_r  <= PC_RST;
            seq_r <= ST_EXEC;
            pop_r <= 1'b0;
        end else begin
            pc_r  <= pc_nxt;
            seq_r <= seq_nxt;
            pop_r <= pop_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            memAddr_r <= '0;
            memWr_r   <= ZERO_BYTE;
            memWrEn_r <= 1'b0;
            discard_r <= 1'b0;
        end else begin
            memAddr_r <= memAddr_nxt;
            memWr_r   <= memWr_nxt;
            memWrEn_r <= memWrEn_nxt;
            discard_r <= discard_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        memAddr        = (seq_r == ST_EXEC) ? instAddr : memAddr_r;
        memWrData      = memWr_r;
        memWrEn        = memWrEn_r;
        stackPop       = pop_r;
        instReady      = (seq_r == ST_EXEC) && !reset;
        fetchDiscard   = discard_r;
        acc            = acc_r;
        pc             = pc_r;
        carryFlag      = flags_r[FLG_CARRY];
        nibbleHalfFlag = flags_r[FLG_HALF];
        signedWrapFlag = flags_r[FLG_WRAP];
        zeroFlag       = flags_r[FLG_ZERO];
    end

endmodule : mcu_move_logic_rotate_exec

/* File: hdl/rotate_unit.sv */
// rotate left/right with optional carry path
`timescale 1ns/10ps
module rotate_unit
    import exec_pkg::*;
(
    // operand
    input  wire logic [exec_pkg::DATA_W-1:0] operand,
    input  wire logic                        carryIn,
    // control
    input  wire logic                        toRight,
    input  wire logic                        viaCarry,
    // result
    output logic      [exec_pkg::DATA_W-1:0] result,
    output logic                             carryOut
);
    logic fillBit;

    always_comb begin
        fillBit  = viaCarry ? carryIn : (toRight ? operand[0] : operand[DATA_W-1]);
        if (toRight) begin
            result   = {fillBit, operand[DATA_W-1:1]};
            carryOut = operand[0];
        end else begin
            result   = {operand[DATA_W-2:0], fillBit};
            carryOut = operand[DATA_W-1];
        end
    end
endmodule : rotate_unit

/* File: hdl/sub_borrow_unit.sv */
// accumulator plus complemented operand plus carry, with flags
`timescale 1ns/10ps
module sub_borrow_unit
    import exec_pkg::*;
(
    // operands
    input  wire logic [exec_pkg::DATA_W-1:0] accIn,
    input  wire logic [exec_pkg::DATA_W-1:0] memIn,
    input  wire logic                        carryIn,
    // result and flags
    output logic      [exec_pkg::DATA_W-1:0] diff,
    output logic                             carryOut,
    output logic                             halfOut,
    output logic                             wrapOut,
    output logic                             zeroOut
);
    logic [DATA_W-1:0] notMem;
    logic [DATA_W:0]   fullSum;
    logic [4:0]        lowSum;

    always_comb begin
        notMem   = ~memIn;
        fullSum  = {1'b0, accIn} + {1'b0, notMem} + {8'h00, carryIn};
        lowSum   = {1'b0, accIn[3:0]} + {1'b0, notMem[3:0]} + {4'h0, carryIn};
        diff     = fullSum[DATA_W-1:0];
        carryOut = fullSum[DATA_W];
        halfOut  = lowSum[4];
        wrapOut  = (accIn[DATA_W-1] == notMem[DATA_W-1]) && (diff[DATA_W-1] != accIn[DATA_W-1]);
        zeroOut  = (diff == ZERO_BYTE);
    end
endmodule : sub_borrow_unit
